// file: design/gfx_interrupt_sources_watchdog.v
// How it works
// - watchdog counts every render clock while running
// - writing one stops watchdog, clears count
// - threshold match raises media hang, wraps
// - bits 31 to 26 reserved, no source
// - bit 25 media parser user interrupt
// - bit 24 context switch, needs run list
// - bit 23 follows pending page fault
// - bits 22/21 display A/B scan line
// - bits 20/19 media/bitstream counter exceeded
// - bit 18 fence notify request
// - bit 15 clears after error source cleared
// - unmasked error status drives master error
// - bit 14 thermal sensor event
// - bit 12 toggles per completed sync flush
// - bits 11/10 plane A/B flip pending
// - bit 9 overlay flip pending, instructions only
// - bit 8 plane C flip pending
// - bits 7/5 delayed vertical blank leading edge
// - bits 6/4 rising edge unmasked pipe events
// - bits 2/1/0 debug, render user, system event
`timescale 1ns/1ps
`default_nettype none
`include "gfx_irq_consts.vh"

module gfx_interrupt_sources_watchdog #(
  parameter ERR_W  = 8,
  parameter PEVT_W = 8
) (
  input  wire              mclk,
  input  wire              rst,
  input  wire              ce,
  input  wire              reg_wr,
  input  wire              reg_rd,
  input  wire [15:0]       reg_addr,
  input  wire [31:0]       reg_wdata,
  output reg  [31:0]       reg_rdata_r,
  output reg               reg_rvalid_r,
  input  wire              media_user_intr,
  input  wire              ctx_switch_done,
  input  wire              run_list_enable,
  input  wire              page_fault_pending,
  input  wire              vline_a,
  input  wire              vline_b,
  input  wire              media_pipe_exceeded,
  input  wire              bitstream_pipe_exceeded,
  input  wire              fence_notify,
  input  wire [ERR_W-1:0]  err_status,
  input  wire [ERR_W-1:0]  err_mask,
  input  wire              thermal_event,
  input  wire              sync_flush_done,
  input  wire              sync_enable,
  input  wire              engines_flushed,
  input  wire              flip_pending_a,
  input  wire              flip_pending_b,
  input  wire              overlay_flip_pending,
  input  wire              flip_pending_c,
  input  wire [1:0]        vertical_blank_lead,
  input  wire [1:0]        vertical_blank_done,
  input  wire [PEVT_W-1:0] pipe_event_bits_a,
  input  wire [PEVT_W-1:0] pipe_event_mask_a,
  input  wire [PEVT_W-1:0] pipe_event_bits_b,
  input  wire [PEVT_W-1:0] pipe_event_mask_b,
  input  wire              eu_debug_intr,
  input  wire              render_user_intr,
  input  wire              system_event_config_wr,
  input  wire              identity_clear_wr,
  input  wire [31:0]       identity_clear_data,
  output reg  [31:0]       identity_r,
  output reg               media_hang_r,
  output reg               watchdog_running_r
);

  // ****************************************************************
  // register decode
  // ****************************************************************

  reg  [31:0] wdog_ctrl_r;
  reg  [31:0] wdog_thresh_r;
  wire        hit_ctrl;
  wire        hit_thresh;
  wire        hit_count;
  wire        wdog_start;
  wire        wdog_stop;
  wire [31:0] wdog_count;
  wire        wdog_running;
  wire        wdog_hang;

  // address compares; control and threshold shared by read and write paths, count used by reads only
  assign hit_ctrl   = (reg_addr == `WDOG_CTRL_OFS);
  assign hit_thresh = (reg_addr == `WDOG_THRESH_OFS);
  assign hit_count  = (reg_addr == `WDOG_COUNT_OFS);

  // the control register is a command port: only the exact values zero
  // and one act on the counter, so a stray bit pattern written by
  // software is held for read-back but can neither start nor stop it
  assign wdog_start = reg_wr & hit_ctrl & (reg_wdata == `WDOG_CMD_START);
  assign wdog_stop  = reg_wr & hit_ctrl & (reg_wdata == `WDOG_CMD_STOP);

  // ****************************************************************
  // writable registers
  // ****************************************************************

  // control keeps the last command for read-back
  // threshold changes take effect at once, even mid-count; a new value
  // below the running count lets the counter pass it and wrap naturally
  always @(posedge mclk) begin
    if (rst) begin
      wdog_ctrl_r   <= `WDOG_CTRL_RST;
      wdog_thresh_r <= `WDOG_THRESH_RST;
    end else if (ce) begin
      if (reg_wr && hit_ctrl) begin
        wdog_ctrl_r <= reg_wdata;
      end
      if (reg_wr && hit_thresh) begin
        wdog_thresh_r <= reg_wdata;
      end
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************

  reg [31:0] rdata_nxt;

  // unmapped offsets answer zero
  // the count register shows the live count; it is a debug view only,
  // since the value moves every clock while the watchdog runs
  always @* begin
    rdata_nxt = 32'h00000000;
    if (hit_ctrl) begin
      rdata_nxt = wdog_ctrl_r;
    end else if (hit_thresh) begin
      rdata_nxt = wdog_thresh_r;
    end else if (hit_count) begin
      rdata_nxt = wdog_count;
    end
  end

  // one cycle read latency
  always @(posedge mclk) begin
    if (rst) begin
      reg_rdata_r  <= 32'h00000000;
      reg_rvalid_r <= 1'b0;
    end else if (ce) begin
      reg_rvalid_r <= reg_rd;
      if (reg_rd) begin
        reg_rdata_r <= rdata_nxt;
      end
    end
  end

  // ****************************************************************
  // watchdog counter
  // ****************************************************************

  // the counter lives in its own module so its wrap and stop logic can be
  // reused; start and stop are one-cycle strobes from the write decode
  render_watchdog #(
    .CW        (32)
  ) u_watchdog (
    .mclk      (mclk),
    .rst       (rst),
    .ce        (ce),
    .start     (wdog_start),
    .stop      (wdog_stop),
    .threshold (wdog_thresh_r),
    .count_r   (wdog_count),
    .running_r (wdog_running),
    .hang_r    (wdog_hang)
  );

  // hang pulse and run state mirrored to top-level flops
  // both lag the counter by one clock; the identity bit uses the internal
  // pulse so it rises in the same cycle as the media hang output
  always @(posedge mclk) begin
    if (rst) begin
      media_hang_r       <= 1'b0;
      watchdog_running_r <= 1'b0;
    end else if (ce) begin
      media_hang_r       <= wdog_hang;
      watchdog_running_r <= wdog_running;
    end
  end

  // ****************************************************************
  // display pipe edge and blank tracking, one copy per pipe
  // ****************************************************************

  wire [1:0] pipe_or;
  reg  [1:0] pipe_or_q_r;
  reg  [1:0] vertical_blank_q_r;
  reg  [1:0] vertical_blank_arm_r;
  wire [1:0] pipe_evt_rise;
  wire [1:0] vertical_blank_set;

  // only unmasked event bits take part in the OR
  // unmasking a standing event counts as a rising edge, which is what
  // software expects after it re-enables a cause in the pipe status
  assign pipe_or[0] = |(pipe_event_bits_a & ~pipe_event_mask_a);
  assign pipe_or[1] = |(pipe_event_bits_b & ~pipe_event_mask_b);

  genvar gp;
  generate
    for (gp = 0; gp < 2; gp = gp + 1) begin : g_pipe
      // arm on blank leading edge, fire once blank-time updates finish
      always @(posedge mclk) begin
        if (rst) begin
          pipe_or_q_r[gp]          <= 1'b0;
          vertical_blank_q_r[gp]   <= 1'b0;
          vertical_blank_arm_r[gp] <= 1'b0;
        end else if (ce) begin
          pipe_or_q_r[gp]        <= pipe_or[gp];
          vertical_blank_q_r[gp] <= vertical_blank_lead[gp];
          if (vertical_blank_set[gp]) begin
            vertical_blank_arm_r[gp] <= 1'b0;
          end else if (vertical_blank_lead[gp] && !vertical_blank_q_r[gp]) begin
            vertical_blank_arm_r[gp] <= 1'b1;
          end
        end
      end
      assign pipe_evt_rise[gp] = pipe_or[gp] & ~pipe_or_q_r[gp];
      // a new leading edge with updates already done fires at once
      assign vertical_blank_set[gp] = vertical_blank_done[gp] &
                                      (vertical_blank_arm_r[gp] |
                                       (vertical_blank_lead[gp] & ~vertical_blank_q_r[gp]));
    end
  endgenerate

  // ****************************************************************
  // sync flush toggle and master error
  // ****************************************************************

  reg  sync_flush_q_r;
  wire sync_toggle;
  wire err_active;

  // edge of the flush-done strobe so a held level toggles once
  // a flush reported before all engines are idle is dropped, not deferred;
  // the parser must report again once the engines have drained
  always @(posedge mclk) begin
    if (rst) begin
      sync_flush_q_r <= 1'b0;
    end else if (ce) begin
      sync_flush_q_r <= sync_flush_done;
    end
  end

  assign sync_toggle = sync_flush_done & ~sync_flush_q_r & sync_enable & engines_flushed;
  assign err_active  = |(err_status & ~err_mask);

  // ****************************************************************
  // interrupt identity bits
  // ****************************************************************

  reg [31:0] set_vec;
  reg [31:0] level_vec;
  reg [31:0] clr_vec;
  reg [31:0] ident_nxt;

  // event sources gathered at their bit positions
  always @* begin
    set_vec = 32'h00000000;
    set_vec[`IB_MEDIA_USER]     = media_user_intr;
    set_vec[`IB_CTX_SWITCH]     = ctx_switch_done & run_list_enable;
    set_vec[`IB_VLINE_A]        = vline_a;
    set_vec[`IB_VLINE_B]        = vline_b;
    set_vec[`IB_MEDIA_HANG]     = media_pipe_exceeded | wdog_hang;
    set_vec[`IB_BITSTREAM_HANG] = bitstream_pipe_exceeded;
    set_vec[`IB_FENCE_NOTIFY]   = fence_notify;
    set_vec[`IB_MASTER_ERR]     = err_active;
    set_vec[`IB_THERMAL]        = thermal_event;
    set_vec[`IB_VERTICAL_BLANK_A] = vertical_blank_set[0];
    set_vec[`IB_PIPE_EVT_A]     = pipe_evt_rise[0];
    set_vec[`IB_VERTICAL_BLANK_B] = vertical_blank_set[1];
    set_vec[`IB_PIPE_EVT_B]     = pipe_evt_rise[1];
    set_vec[`IB_EU_DEBUG]       = eu_debug_intr;
    set_vec[`IB_RENDER_USER]    = render_user_intr;
    set_vec[`IB_SYS_EVENT]      = system_event_config_wr;
  end

  // pending conditions mirrored straight into their bits
  always @* begin
    level_vec = 32'h00000000;
    level_vec[`IB_PAGE_FAULT]   = page_fault_pending;
    level_vec[`IB_FLIP_A]       = flip_pending_a;
    level_vec[`IB_FLIP_B]       = flip_pending_b;
    level_vec[`IB_OVERLAY_FLIP] = overlay_flip_pending;
    level_vec[`IB_FLIP_C]       = flip_pending_c;
  end

  // write-one-to-clear; master error waits for its source to go away
  // so software must clear the error cause first, else the clear is lost
  // and the bit stays up, which keeps the interrupt from being missed
  always @* begin
    clr_vec = 32'h00000000;
    if (identity_clear_wr) begin
      clr_vec = identity_clear_data & `IDENT_STICKY_MASK;
    end
    if (err_active) begin
      clr_vec[`IB_MASTER_ERR] = 1'b0;
    end
  end

  wire [31:0] sticky_nxt;
  wire [31:0] level_nxt;
  wire [31:0] toggle_vec;
  wire [31:0] toggle_nxt;

  // sticky bits: set wins over a clear in the same cycle
  assign sticky_nxt = ((identity_r & ~clr_vec) | set_vec) & `IDENT_STICKY_MASK;
  // level bits follow their source one clock late; clears cannot touch them
  assign level_nxt  = level_vec & `IDENT_LEVEL_MASK;
  // the sync bit flips once per qualified flush and is never cleared
  assign toggle_vec = {19'h00000, sync_toggle, 12'h000};
  assign toggle_nxt = (identity_r ^ toggle_vec) & `IDENT_TOGGLE_MASK;

  // the three classes merged, then reserved positions forced low
  always @* begin
    ident_nxt = sticky_nxt | level_nxt | toggle_nxt;
    // reserved and unused positions never hold a one
    ident_nxt[31:26] = 6'h00;
    ident_nxt[17:16] = 2'h0;
    ident_nxt[13]    = 1'b0;
    ident_nxt[3]     = 1'b0;
  end

  // identity register; held while the clock enable is low
  always @(posedge mclk) begin
    if (rst) begin
      identity_r <= `IDENT_RST;
    end else if (ce) begin
      identity_r <= ident_nxt;
    end
  end

endmodule // gfx_interrupt_sources_watchdog

`default_nettype wire

// file: design/render_watchdog.v
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// render clock watchdog counter
// ****************************************************************
module render_watchdog #(
  parameter CW = 32
) (
  input  wire          mclk,
  input  wire          rst,
  input  wire          ce,
  input  wire          start,
  input  wire          stop,
  input  wire [CW-1:0] threshold,
  output reg  [CW-1:0] count_r,
  output reg           running_r,
  output reg           hang_r
);

  // stop beats start if both arrive together
  always @(posedge mclk) begin
    if (rst) begin
      count_r   <= {CW{1'b0}};
      running_r <= 1'b0;
      hang_r    <= 1'b0;
    end else if (ce) begin
      hang_r <= 1'b0;
      if (stop) begin
        running_r <= 1'b0;
        count_r   <= {CW{1'b0}};
      end else begin
        if (start) begin
          running_r <= 1'b1;
        end
        if (running_r) begin
          // threshold zero fires every cycle; software loads it first
          if (count_r == threshold) begin
            count_r <= {CW{1'b0}};
            hang_r  <= 1'b1;
          end else begin
            count_r <= count_r + {{(CW-1){1'b0}}, 1'b1};
          end
        end
      end
    end
  end

endmodule // render_watchdog

`default_nettype wire

// file: pkg/gfx_irq_consts.vh
`ifndef GFX_IRQ_CONSTS_VH
`define GFX_IRQ_CONSTS_VH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define WDOG_CTRL_OFS        16'h2178
`define WDOG_THRESH_OFS      16'h217C
`define WDOG_COUNT_OFS       16'h2190

// ****************************************************************
// reset values
// ****************************************************************
`define WDOG_CTRL_RST        32'h00000000
`define WDOG_THRESH_RST      32'h00145855
`define WDOG_COUNT_RST       32'h00000000
`define IDENT_RST            32'h00000000

// ****************************************************************
// watchdog control command values
// ****************************************************************
`define WDOG_CMD_START       32'h00000000
`define WDOG_CMD_STOP        32'h00000001

// ****************************************************************
// interrupt bit positions
// ****************************************************************
`define IB_MEDIA_USER        25
`define IB_CTX_SWITCH        24
`define IB_PAGE_FAULT        23
`define IB_VLINE_A           22
`define IB_VLINE_B           21
`define IB_MEDIA_HANG        20
`define IB_BITSTREAM_HANG    19
`define IB_FENCE_NOTIFY      18
`define IB_MASTER_ERR        15
`define IB_THERMAL           14
`define IB_SYNC_STATUS       12
`define IB_FLIP_A            11
`define IB_FLIP_B            10
`define IB_OVERLAY_FLIP      9
`define IB_FLIP_C            8
`define IB_VERTICAL_BLANK_A  7
`define IB_PIPE_EVT_A        6
`define IB_VERTICAL_BLANK_B  5
`define IB_PIPE_EVT_B        4
`define IB_EU_DEBUG          2
`define IB_RENDER_USER       1
`define IB_SYS_EVENT         0

// ****************************************************************
// bit classes: sticky event bits, mirrored level bits and the sync toggle bit
// ****************************************************************
`define IDENT_STICKY_MASK    32'h037CC0F7
`define IDENT_LEVEL_MASK     32'h00800F00
`define IDENT_TOGGLE_MASK    32'h00001000

`endif

// file: testbench/gfx_interrupt_sources_watchdog_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "gfx_irq_consts.vh"
bind gfx_interrupt_sources_watchdog gfx_irq_checker i_gfx_irq_checker (.*);

module gfx_interrupt_sources_watchdog_tb;
  logic        mclk, rst, ce, reg_wr, reg_rd, reg_rvalid_r, media_hang_r;
  logic        watchdog_running_r, mdl_on, oa, ob, identity_clear_wr;
  logic        media_user_intr, ctx_switch_done, run_list_enable, page_fault_pending;
  logic        vline_a, vline_b, media_pipe_exceeded, bitstream_pipe_exceeded, fence_notify;
  logic        thermal_event, sync_flush_done, sync_enable, engines_flushed, flip_pending_a;
  logic        flip_pending_b, overlay_flip_pending, flip_pending_c, eu_debug_intr;
  logic        render_user_intr, system_event_config_wr;
  logic [1:0]  vertical_blank_lead, vertical_blank_done, arm, rise, fire;
  logic [4:0]  pv;
  logic [7:0]  err_status, err_mask, pipe_event_bits_a, pipe_event_mask_a;
  logic [7:0]  pipe_event_bits_b, pipe_event_mask_b;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_r, identity_clear_data, identity_r, exp_id, s;
  integer      seed, n_mismatch, samples_checked, t, k;

  gfx_interrupt_sources_watchdog i_gfx_interrupt_sources_watchdog (.*);

  // free-running clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked = samples_checked + 1;
    if (seen !== want) begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic complete_run;
    if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // all event and level sources from two words
  task automatic drive(input logic [31:0] a, input logic [31:0] b);
    {media_user_intr, ctx_switch_done, run_list_enable, page_fault_pending, vline_a,
     vline_b, media_pipe_exceeded, bitstream_pipe_exceeded, fence_notify, thermal_event,
     sync_flush_done, sync_enable, engines_flushed, flip_pending_a, flip_pending_b,
     overlay_flip_pending, flip_pending_c, eu_debug_intr, render_user_intr,
     system_event_config_wr, identity_clear_wr, vertical_blank_lead,
     vertical_blank_done} <= a[24:0];
    {err_status, err_mask, pipe_event_bits_a, pipe_event_mask_a} <= b;
    {pipe_event_bits_b, pipe_event_mask_b} <= a[31:16] ^ b[15:0];
    identity_clear_data <= a ^ b;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk({31'h0, reg_rvalid_r}, 32'h1);
    chk(reg_rdata_r, e);
  endtask

  // identity model: sticky sets win over clears, levels mirror, edges detected
  always @(posedge mclk) begin
    if (mdl_on) begin
      if (!rst) chk(identity_r, exp_id);
      oa = |(pipe_event_bits_a & ~pipe_event_mask_a);
      ob = |(pipe_event_bits_b & ~pipe_event_mask_b);
      rise = vertical_blank_lead & ~pv[1:0];
      fire = (rise | arm) & vertical_blank_done;
      s = {6'h0, media_user_intr, ctx_switch_done & run_list_enable, 1'b0, vline_a,
           vline_b, media_pipe_exceeded, bitstream_pipe_exceeded, fence_notify, 2'h0,
           |(err_status & ~err_mask), thermal_event, 6'h0, fire[0], oa & ~pv[3], fire[1],
           ob & ~pv[2], 1'b0, eu_debug_intr, render_user_intr, system_event_config_wr};
      if (rst) begin
        exp_id = 32'h0;
        pv = 5'h0;
        arm = 2'h0;
      end else if (ce) begin
        exp_id = exp_id & ~({32{identity_clear_wr}} & identity_clear_data & `IDENT_STICKY_MASK);
        exp_id = exp_id | s;
        exp_id[23] = page_fault_pending;
        exp_id[11:8] = {flip_pending_a, flip_pending_b, overlay_flip_pending, flip_pending_c};
        exp_id[12] = exp_id[12] ^ (sync_flush_done & ~pv[4] & sync_enable & engines_flushed);
        arm = (rise | arm) & ~vertical_blank_done;
        pv = {sync_flush_done, oa, ob, vertical_blank_lead};
      end
    end
  end

  // hang guard
  initial begin
    repeat (10000) @(posedge mclk);
    n_mismatch = n_mismatch + 1;
    complete_run;
  end

  initial begin
    seed = 51;
    n_mismatch = 0;
    samples_checked = 0;
    mdl_on <= 1'b0;
    rst <= 1'b1;
    ce <= 1'b1;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= 16'h0000;
    reg_wdata <= 32'h00000000;
    drive(32'h0, 32'h0);
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rd(16'h2178, `WDOG_CTRL_RST);
    rd(16'h217C, `WDOG_THRESH_RST);
    rd(16'h2190, `WDOG_COUNT_RST);
    rd(16'h2000, 32'h0);
    wr(16'h2178, 32'h2);
    wr(16'h2190, 32'h5);
    rd(16'h2178, 32'h2);
    rd(16'h2190, 32'h0);
    chk({31'h0, watchdog_running_r}, 32'h0);
    t = 3 + ($random(seed) & 7);
    wr(16'h217C, t[31:0]);
    wr(16'h2178, `WDOG_CMD_START);
    // first hang after t+1 counts, then every t+1 cycles
    for (k = 1; k < 4 * t + 6; k = k + 1) begin
      @(posedge mclk);
      #1;
      chk({31'h0, k >= t + 2 && (k - t - 2) % (t + 1) == 0}, {31'h0, media_hang_r});
      chk({31'h0, watchdog_running_r}, 32'h1);
    end
    chk({31'h0, identity_r[20]}, 32'h1);
    wr(16'h2178, `WDOG_CMD_STOP);
    rd(16'h2190, 32'h0);
    repeat (2 * t + 4) begin
      @(posedge mclk);
      #1;
      chk({30'h0, media_hang_r, watchdog_running_r}, 32'h0);
    end
    // second reset, then random sources against the model
    @(posedge mclk);
    rst <= 1'b1;
    mdl_on <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (3000) begin
      drive($random(seed), $random(seed));
      ce <= ($random(seed) & 7) != 0;
      @(posedge mclk);
    end
    complete_run;
  end
endmodule // gfx_interrupt_sources_watchdog_tb
`default_nettype wire

// file: testbench/gfx_irq_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// port-level checker
// ********
module gfx_irq_checker (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_rvalid_r,
  input wire logic [31:0] identity_r,
  input wire logic        media_hang_r,
  input wire logic        watchdog_running_r,
  input wire logic        thermal_event,
  input wire logic        page_fault_pending,
  input wire logic        flip_pending_a,
  input wire logic        media_user_intr,
  input wire logic        fence_notify
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // read answer follows each read by one cycle and never comes without one
  a_rvalid_next: assert property (ce && reg_rd |=> reg_rvalid_r)
    else $error("read answer missing");
  a_rvalid_pulse: assert property (ce && !reg_rd |=> !reg_rvalid_r)
    else $error("read answer without read");
  a_reserved_zero: assert property (identity_r[31:26] == 6'h0 && identity_r[17:16] == 2'h0
    && !identity_r[13] && !identity_r[3]) else $error("reserved identity bit set");
  a_thermal_set: assert property (ce && thermal_event |=> identity_r[14])
    else $error("thermal bit not set");
  a_user_set: assert property (ce && media_user_intr |=> identity_r[25])
    else $error("media user bit not set");
  a_fence_set: assert property (ce && fence_notify |=> identity_r[18])
    else $error("fence bit not set");
  a_fault_mirror: assert property (ce |=> identity_r[23] == $past(page_fault_pending))
    else $error("page fault bit not mirrored");
  a_flip_mirror: assert property (ce |=> identity_r[11] == $past(flip_pending_a))
    else $error("flip bit not mirrored");
  a_hang_sets: assert property (media_hang_r |-> identity_r[20])
    else $error("hang pulse without identity bit");
  a_start_runs: assert property (ce && reg_wr && reg_addr == 16'h2178
    && reg_wdata == 32'h0 ##1 (ce && !reg_wr) |=> watchdog_running_r)
    else $error("watchdog not started");
  a_stop_halts: assert property (ce && reg_wr && reg_addr == 16'h2178
    && reg_wdata == 32'h1 ##1 (ce && !reg_wr) |=> !watchdog_running_r)
    else $error("watchdog not stopped");
endmodule // gfx_irq_checker
`default_nettype wire
